// ### rtl/cbpm_seq.sv
`timescale 1ns/100ps
module cbpm_seq (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cfg_ps_wr_i,
    input wire logic [1:0] cfg_ps_i,
    input wire logic cfg_en_wr_i,
    input wire logic cfg_en_i,
    input wire logic flag_clr_i,
    input wire logic cyc_valid_i,
    input wire logic cyc_type0_cfg_i,
    input wire logic cyc_own_func_i,
    input wire logic aux_power_i,
    input wire logic main_power_lost_i,
    input wire logic card_present_i,
    input wire logic card_wake_i,
    input wire logic card_int_i,
    input wire logic sock_event_i,
    input wire logic vcc_wr_i,
    input wire logic [1:0] vcc_sel_i,
    input wire logic func_reset_i,
    output logic cclk_o,
    output logic crst_n_o,
    output logic cyc_claim_o,
    output logic int_o,
    output logic pme_n_o,
    output logic [1:0] vcc_sel_o,
    output logic [1:0] power_state_field_o,
    output logic wake_event_enable_o,
    output logic wake_event_flag_o,
    output logic card_removed_o,
    output logic context_valid_o
);
    cbpm_if w ();
    cbpm_wake u_wake (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .w(w)
    );

    cbpm_pkg::cbpm_state_t state_q;
    logic [1:0] ps_q;
    logic present_q;
    logic removed_q;
    logic [1:0] vsel_q;
    logic div_q;
    logic in_d3;
    logic low_pwr;

    function automatic logic is_d3(input cbpm_pkg::cbpm_state_t s);
        return (s == cbpm_pkg::CBPM_D3_HOT) || (s == cbpm_pkg::CBPM_D3_COLD);
    endfunction : is_d3

    assign in_d3 = is_d3(state_q);
    assign low_pwr = in_d3 || (ps_q != cbpm_pkg::PS_D0);

    // power state sequencing
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            state_q <= cbpm_pkg::CBPM_D0_UNINIT;
            ps_q <= cbpm_pkg::PS_RESET;
        end
        else
        begin
            case (state_q)
                cbpm_pkg::CBPM_D0_UNINIT, cbpm_pkg::CBPM_ACTIVE:
                begin
                    if (cfg_ps_wr_i)
                    begin
                        ps_q <= cfg_ps_i;
                        if (cfg_ps_i == cbpm_pkg::PS_D3)
                            state_q <= cbpm_pkg::CBPM_D3_HOT;
                        else
                            state_q <= cbpm_pkg::CBPM_ACTIVE;
                    end
                end
                cbpm_pkg::CBPM_D3_HOT:
                begin
                    if (main_power_lost_i && aux_power_i)
                        state_q <= cbpm_pkg::CBPM_D3_COLD;
                    else if (cfg_ps_wr_i && cfg_ps_i == cbpm_pkg::PS_D0)
                    begin
                        state_q <= cbpm_pkg::CBPM_D0_UNINIT;
                        ps_q <= cbpm_pkg::PS_D0;
                    end
                end
                default:
                    state_q <= cbpm_pkg::CBPM_D3_COLD;
            endcase
        end
    end

    // card presence and removal detect, active in all states
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            present_q <= 1'b0;
            removed_q <= 1'b0;
        end
        else
        begin
            present_q <= card_present_i;
            removed_q <= present_q && !card_present_i;
        end
    end

    // socket supply: frozen in D3 except on removal, which turns it off in any low-power state
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            vsel_q <= cbpm_pkg::VSEL_OFF;
        else if (removed_q && low_pwr)
            vsel_q <= cbpm_pkg::VSEL_OFF;
        else if (vcc_wr_i && !in_d3)
            vsel_q <= vcc_sel_i;
    end

    // socket clock divider, stopped low in D3
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || in_d3)
            div_q <= 1'b0;
        else
            div_q <= !div_q;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            cclk_o <= 1'b0;
            crst_n_o <= 1'b0;
        end
        else
        begin
            cclk_o <= div_q && !in_d3;
            crst_n_o <= !in_d3 && !func_reset_i;
        end
    end

    // cycle claim decode
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            cyc_claim_o <= 1'b0;
        else if (state_q == cbpm_pkg::CBPM_D3_COLD)
            cyc_claim_o <= 1'b0;
        else if (state_q == cbpm_pkg::CBPM_D3_HOT)
            cyc_claim_o <= cyc_valid_i && cyc_type0_cfg_i && cyc_own_func_i;
        else
            cyc_claim_o <= cyc_valid_i;
    end

    // interrupts only outside D3
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            int_o <= 1'b0;
        else
            int_o <= !in_d3 && (card_int_i || sock_event_i);
    end

    // wake context
    assign w.cfg_wr = cfg_ps_wr_i;
    assign w.cfg_ps = cfg_ps_i;
    assign w.cfg_en_wr = cfg_en_wr_i;
    assign w.cfg_en = cfg_en_i;
    assign w.flag_clr = flag_clr_i;
    assign w.card_removed = removed_q;
    assign w.wake_req = w.wake_en && low_pwr && (card_wake_i || removed_q);

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            pme_n_o <= 1'b1;
            wake_event_enable_o <= 1'b0;
            wake_event_flag_o <= 1'b0;
            power_state_field_o <= cbpm_pkg::PS_RESET;
            vcc_sel_o <= cbpm_pkg::VSEL_OFF;
            card_removed_o <= 1'b0;
            context_valid_o <= 1'b0;
        end
        else
        begin
            pme_n_o <= !(w.wake_flag && w.wake_en);
            wake_event_enable_o <= w.wake_en;
            wake_event_flag_o <= w.wake_flag;
            power_state_field_o <= ps_q;
            vcc_sel_o <= vsel_q;
            card_removed_o <= removed_q;
            context_valid_o <= !in_d3;
        end
    end
endmodule : cbpm_seq

// ### rtl/cbpm_pkg.sv
package cbpm_pkg;
    // power_state_field encodings
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;
    localparam logic [1:0] PS_RESET = 2'h0;
    localparam int CCLK_DIV = 2;
    localparam logic VCC_OFF = 1'b0;
    localparam logic [1:0] VSEL_OFF = 2'h0;
    typedef enum logic [1:0] {
        CBPM_D0_UNINIT,
        CBPM_ACTIVE,
        CBPM_D3_HOT,
        CBPM_D3_COLD
    } cbpm_state_t;
endpackage : cbpm_pkg

// ### rtl/cbpm_if.sv
`timescale 1ns/100ps
interface cbpm_if;
    logic cfg_wr;
    logic [1:0] cfg_ps;
    logic cfg_en_wr;
    logic cfg_en;
    logic flag_clr;
    logic card_removed;
    logic wake_req;
    logic wake_flag;
    logic wake_en;
    modport ctl (input cfg_wr, input cfg_ps, input cfg_en_wr, input cfg_en, input flag_clr,
        input card_removed, input wake_req, output wake_flag, output wake_en);
    modport top (output cfg_wr, output cfg_ps, output cfg_en_wr, output cfg_en, output flag_clr,
        output card_removed, output wake_req, input wake_flag, input wake_en);
endinterface : cbpm_if

// ### rtl/cbpm_wake.sv
`timescale 1ns/100ps
// wake-event context: enable and sticky flag, kept across D3
module cbpm_wake (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    cbpm_if.ctl w
);
    logic en_q;
    logic flag_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            en_q <= 1'b0;
        else if (w.cfg_en_wr)
            en_q <= w.cfg_en;
    end

    // set wins over clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            flag_q <= 1'b0;
        else if (w.wake_req)
            flag_q <= 1'b1;
        else if (w.flag_clr)
            flag_q <= 1'b0;
    end

    assign w.wake_flag = flag_q;
    assign w.wake_en = en_q;
endmodule : cbpm_wake

// ### verification/cbpm_card_model.sv
`timescale 1ns/100ps
// card in the socket: a card held in reset sits in D3 and raises nothing
module cbpm_card_model (
    input wire logic clk_sys_i,
    input wire logic crst_n_i,
    input wire logic inserted_i,
    output logic card_present_o,
    output logic card_int_o,
    output logic card_wake_o
);
    always_ff @(posedge clk_sys_i)
    begin
        card_present_o <= inserted_i;
        card_int_o <= inserted_i && crst_n_i;
        card_wake_o <= 1'b0;
    end
endmodule : cbpm_card_model

// ### verification/cbpm_seq_properties.sv
`timescale 1ns/100ps
module cbpm_seq_checker (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cyc_type0_cfg_i,
    input wire logic cyc_own_func_i,
    input wire logic card_present_i,
    input wire logic cclk_o,
    input wire logic crst_n_o,
    input wire logic cyc_claim_o,
    input wire logic int_o,
    input wire logic pme_n_o,
    input wire logic [1:0] vcc_sel_o,
    input wire logic [1:0] power_state_field_o,
    input wire logic wake_event_enable_o,
    input wire logic wake_event_flag_o,
    input wire logic card_removed_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    logic d3;
    assign d3 = power_state_field_o == cbpm_pkg::PS_D3;
    a_clock_stopped:
    assert property (d3 && $past(d3) |-> !cclk_o) else $error("socket clock runs in D3");
    a_socket_reset_low:
    assert property (d3 |-> !crst_n_o) else $error("socket reset released in D3");
    a_no_irq:
    assert property (d3 && $past(d3) |-> !int_o) else $error("interrupt in D3");
    a_wake_gated:
    assert property ($fell(pme_n_o) |-> wake_event_enable_o) else $error("wake without enable");
    a_removal_seen:
    assert property ($fell(card_present_i) |-> ##[1:4] card_removed_o) else $error("removal missed");
    a_supply_kept:
    assert property (d3 && $past(d3) && !card_removed_o && !$past(card_removed_o) |-> $stable(vcc_sel_o))
        else $error("supply moved");
    a_supply_off:
    assert property (card_removed_o && d3 |=> vcc_sel_o == cbpm_pkg::VSEL_OFF) else $error("supply left on");
    a_claim_own:
    assert property (d3 && cyc_claim_o |-> $past(cyc_type0_cfg_i && cyc_own_func_i)) else $error("foreign claim");
    a_flag_kept:
    assert property (card_removed_o && wake_event_enable_o && d3 |=> wake_event_flag_o) else $error("flag not set");
    cover property (card_removed_o && d3);
    cover property (d3 && cyc_claim_o);
    cover property ($fell(pme_n_o));
endmodule : cbpm_seq_checker
bind cbpm_seq cbpm_seq_checker cbpm_seq_checker_i (.clk_sys_i, .resetn_i, .cyc_type0_cfg_i, .cyc_own_func_i,
    .card_present_i, .cclk_o, .crst_n_o, .cyc_claim_o, .int_o, .pme_n_o, .vcc_sel_o, .power_state_field_o,
    .wake_event_enable_o, .wake_event_flag_o, .card_removed_o);

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, cfg_ps_wr_i = 1'b0, cfg_en_wr_i = 1'b0, cfg_en_i = 1'b0;
    logic flag_clr_i = 1'b0, cyc_valid_i = 1'b0, cyc_type0_cfg_i = 1'b0, cyc_own_func_i = 1'b0;
    logic aux_power_i = 1'b0, main_power_lost_i = 1'b0, sock_event_i = 1'b0, vcc_wr_i = 1'b0;
    logic func_reset_i = 1'b0, ins = 1'b1;
    logic [1:0] cfg_ps_i = 2'h0, vcc_sel_i = 2'h2;
    logic card_present_i, card_wake_i, card_int_i, cclk_o, crst_n_o, cyc_claim_o, int_o, pme_n_o;
    logic wake_event_enable_o, wake_event_flag_o, card_removed_o, context_valid_o;
    logic [1:0] vcc_sel_o, power_state_field_o;
    int errors = 0;
    int check_count = 0;
    // upper pair: value written, lower pair: field expected
    logic [3:0] rows [5] = '{4'h0, 4'h5, 4'hA, 4'h0, 4'hF};
    cbpm_seq cbpm_seq_i (.*);
    cbpm_card_model cbpm_card_model_i (.clk_sys_i(clk_sys_i), .crst_n_i(crst_n_o), .inserted_i(ins),
        .card_present_o(card_present_i), .card_int_o(card_int_i), .card_wake_o(card_wake_i));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task automatic wr_ps(input logic [1:0] v);
        cfg_ps_i = v;
        cfg_ps_wr_i = 1'b1;
        tick(1);
        cfg_ps_wr_i = 1'b0;
        tick(2);
    endtask : wr_ps
    initial
    begin
        tick(20);
        resetn_i = 1'b1;
        chk({crst_n_o, pme_n_o}, 2'h1);
        vcc_wr_i = 1'b1;
        tick(1);
        vcc_wr_i = 1'b0;
        for (int r = 0; r < 5; r++)
        begin
            wr_ps(rows[r][3:2]);
            chk(power_state_field_o, rows[r][1:0]);
        end
        sock_event_i = 1'b1;
        cyc_valid_i = 1'b1;
        cyc_type0_cfg_i = 1'b1;
        cyc_own_func_i = 1'b1;
        tick(3);
        chk({cclk_o, crst_n_o}, 2'h0);
        chk(context_valid_o, 1'b0);
        chk({int_o, cyc_claim_o}, 2'h1);
        chk(vcc_sel_o, 2'h2);
        cyc_own_func_i = 1'b0;
        tick(2);
        chk({cclk_o, cyc_claim_o}, 2'h0);
        chk(int_o, 1'b0);
        wr_ps(2'h1);
        chk(power_state_field_o, 2'h3);
        cfg_en_i = 1'b1;
        cfg_en_wr_i = 1'b1;
        tick(1);
        cfg_en_wr_i = 1'b0;
        ins = 1'b0;
        for (int i = 0; i < 8 && card_removed_o !== 1'b1; i++)
            tick(1);
        if (card_removed_o !== 1'b1)
        begin
            errors++;
            final_report;
        end
        tick(1);
        chk(vcc_sel_o, 2'h0);
        chk({wake_event_flag_o, wake_event_enable_o}, 2'h3);
        chk({pme_n_o, card_removed_o}, 2'h0);
        chk(power_state_field_o, 2'h3);
        flag_clr_i = 1'b1;
        tick(1);
        flag_clr_i = 1'b0;
        tick(2);
        chk({pme_n_o, wake_event_flag_o}, 2'h2);
        ins = 1'b1;
        wr_ps(2'h0);
        chk(power_state_field_o, 2'h0);
        wr_ps(2'h3);
        aux_power_i = 1'b1;
        main_power_lost_i = 1'b1;
        cyc_own_func_i = 1'b1;
        tick(3);
        chk(cyc_claim_o, 1'b0);
        wr_ps(2'h0);
        chk(power_state_field_o, 2'h3);
        resetn_i = 1'b0;
        tick(2);
        resetn_i = 1'b1;
        chk(power_state_field_o, 2'h0);
        final_report;
    end
endmodule : tb
